// ===== rtl/opc_pkg.sv
// Package for the output pin config and strobe map block
`default_nettype none
package opc_pkg;
   // Header byte layout
   localparam int HDR_RW_BIT = 7;
   localparam int HDR_BURST_BIT = 6;
   localparam logic [7:0] ACC_SINGLE_WR = 8'h00;
   localparam logic [7:0] ACC_BURST_WR = 8'h40;
   localparam logic [7:0] ACC_SINGLE_RD = 8'h80;
   localparam logic [7:0] ACC_BURST_RD = 8'hc0;
   // Register offsets and regions
   localparam logic [5:0] OFS_PIN_TWO = 6'h00;
   localparam logic [5:0] OFS_PIN_ONE = 6'h01;
   localparam logic [5:0] OFS_STROBE_LO = 6'h30;
   localparam logic [5:0] OFS_STROBE_HI = 6'h3d;
   localparam logic [5:0] OFS_POWER_TABLE = 6'h3e;
   // Field positions
   localparam int FLD_POLARITY = 6;
   localparam int FLD_DRIVE = 7;
   localparam int FLD_SEL_MSB = 5;
   // Reset values
   localparam logic [7:0] RST_PIN_TWO = 8'h29;
   localparam logic [7:0] RST_PIN_ONE = 8'h2e;

   typedef enum logic [1:0] {
      AREA_CONFIG,
      AREA_STROBE,
      AREA_STATUS,
      AREA_POWER
   } opc_area_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic burst;
      logic [5:0] addr;
      logic [7:0] wdata;
   } opc_req_t;

   typedef struct packed {
      logic polarity;
      logic [5:0] select;
   } opc_pin_t;
endpackage
`default_nettype wire

// ===== rtl/opc_regmap.sv
// Output pin configuration registers and upper address decode
`default_nettype none
module opc_regmap (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Decoded access from the serial interface
   input wire logic ACC_VALID,
   input wire logic [7:0] ACC_HEADER,
   input wire logic [7:0] ACC_WDATA,
   // Read data returned to the serial interface
   output logic [7:0] ACC_RDATA,
   // Region hits for the rest of the chip
   output logic STROBE_PULSE,
   output logic [5:0] STROBE_CODE,
   output logic STATUS_READ,
   output logic [5:0] STATUS_ADDR,
   input wire logic [7:0] STATUS_DATA,
   output logic POWER_ACCESS,
   output logic POWER_WRITE,
   output logic [7:0] POWER_WDATA,
   input wire logic [7:0] POWER_RDATA,
   // Pin configuration
   output logic [5:0] OUT_PIN_TWO_SELECT,
   output logic OUT_PIN_TWO_POLARITY,
   output logic [5:0] OUT_PIN_ONE_SELECT,
   output logic OUT_PIN_ONE_POLARITY,
   output logic OUT_PIN_DRIVE_STRENGTH,
   // Active level shaping of selected signals
   input wire logic PIN_TWO_SIGNAL,
   input wire logic PIN_ONE_SIGNAL,
   output logic PIN_TWO_LEVEL,
   output logic PIN_ONE_LEVEL
);
   // Reset images, built from the package reset bytes
   localparam opc_pkg::opc_pin_t PIN_TWO_INIT = opc_pkg::opc_pin_t'(opc_pkg::RST_PIN_TWO[6:0]);
   localparam opc_pkg::opc_pin_t PIN_ONE_INIT = opc_pkg::opc_pin_t'(opc_pkg::RST_PIN_ONE[6:0]);
   localparam logic DRIVE_INIT = opc_pkg::RST_PIN_ONE[opc_pkg::FLD_DRIVE];

   // Decoded access
   opc_pkg::opc_req_t req;
   opc_pkg::opc_area_t area;
   // Configuration state
   opc_pkg::opc_pin_t pin_two_r;
   opc_pkg::opc_pin_t pin_two_nxt;
   opc_pkg::opc_pin_t pin_one_r;
   opc_pkg::opc_pin_t pin_one_nxt;
   logic drive_r;
   logic drive_nxt;
   // Region pulses and their payloads
   logic strobe_r;
   logic strobe_nxt;
   logic [5:0] strobe_code_r;
   logic status_r;
   logic status_nxt;
   logic [5:0] status_addr_r;
   logic power_r;
   logic power_nxt;
   logic power_write_r;
   logic power_write_nxt;
   logic [7:0] power_wdata_r;
   // Read data
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rdata_load;

   function automatic logic in_strobe_range(input logic [5:0] a);
      in_strobe_range = (a >= opc_pkg::OFS_STROBE_LO) && (a <= opc_pkg::OFS_STROBE_HI);
   endfunction

   // Region of an access from its offset and kind
   function automatic opc_pkg::opc_area_t decode_area(input logic [5:0] a, input logic rd, input logic b);
      if (a == opc_pkg::OFS_POWER_TABLE) begin
         decode_area = opc_pkg::AREA_POWER;
      end else if (in_strobe_range(a)) begin
         if (rd && b) begin
            decode_area = opc_pkg::AREA_STATUS;
         end else begin
            decode_area = opc_pkg::AREA_STROBE;
         end
      end else begin
         decode_area = opc_pkg::AREA_CONFIG;
      end
   endfunction

   // Polarity above a six-bit selector; bit 7 is handled by the caller
   function automatic opc_pkg::opc_pin_t pin_from_byte(input logic [7:0] d);
      opc_pkg::opc_pin_t p;
      p.polarity = d[opc_pkg::FLD_POLARITY];
      p.select = d[opc_pkg::FLD_SEL_MSB:0];
      return p;
   endfunction

   function automatic logic [7:0] pin_to_byte(input logic top, input opc_pkg::opc_pin_t p);
      pin_to_byte = {top, p};
   endfunction

   function automatic logic area_hit(input opc_pkg::opc_req_t r, input opc_pkg::opc_area_t ar,
                                     input opc_pkg::opc_area_t want);
      area_hit = r.valid && (ar == want);
   endfunction

   function automatic logic cfg_write_hit(input opc_pkg::opc_req_t r, input opc_pkg::opc_area_t ar,
                                          input logic [5:0] ofs);
      cfg_write_hit = r.valid && r.write && (ar == opc_pkg::AREA_CONFIG) && (r.addr == ofs);
   endfunction

   // Header carries access type in its top two bits
   always_comb begin
      req.valid = ACC_VALID;
      req.write = ~ACC_HEADER[opc_pkg::HDR_RW_BIT];
      req.burst = ACC_HEADER[opc_pkg::HDR_BURST_BIT];
      req.addr = ACC_HEADER[5:0];
      req.wdata = ACC_WDATA;
      area = decode_area(req.addr, ~req.write, req.burst);
   end

   // Writes to any other config offset are dropped
   always_comb begin
      pin_two_nxt = pin_two_r;
      pin_one_nxt = pin_one_r;
      drive_nxt = drive_r;
      if (cfg_write_hit(req, area, opc_pkg::OFS_PIN_TWO)) begin
         // Bit 7 has no storage, so it always reads back zero
         pin_two_nxt = pin_from_byte(req.wdata);
      end
      if (cfg_write_hit(req, area, opc_pkg::OFS_PIN_ONE)) begin
         pin_one_nxt = pin_from_byte(req.wdata);
         drive_nxt = req.wdata[opc_pkg::FLD_DRIVE];
      end
   end

   always_comb begin
      strobe_nxt = area_hit(req, area, opc_pkg::AREA_STROBE);
      status_nxt = area_hit(req, area, opc_pkg::AREA_STATUS);
      power_nxt = area_hit(req, area, opc_pkg::AREA_POWER);
      power_write_nxt = power_nxt && req.write;
   end

   // Unknown config offsets and single strobe reads return zero
   always_comb begin
      rdata_load = req.valid && !req.write;
      rdata_nxt = 8'h00;
      case (area)
         opc_pkg::AREA_CONFIG: begin
            if (req.addr == opc_pkg::OFS_PIN_TWO) begin
               rdata_nxt = pin_to_byte(1'b0, pin_two_r);
            end else if (req.addr == opc_pkg::OFS_PIN_ONE) begin
               rdata_nxt = pin_to_byte(drive_r, pin_one_r);
            end else begin
               rdata_nxt = 8'h00;
            end
         end
         opc_pkg::AREA_STATUS: rdata_nxt = STATUS_DATA;
         opc_pkg::AREA_POWER: rdata_nxt = POWER_RDATA;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pin_two_r <= PIN_TWO_INIT;
      end else begin
         pin_two_r <= pin_two_nxt;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pin_one_r <= PIN_ONE_INIT;
      end else begin
         pin_one_r <= pin_one_nxt;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         drive_r <= DRIVE_INIT;
      end else begin
         drive_r <= drive_nxt;
      end
   end

   // Pulses last one cycle because the next value is rebuilt every edge
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         strobe_r <= 1'b0;
         strobe_code_r <= 6'h00;
      end else begin
         strobe_r <= strobe_nxt;
         strobe_code_r <= req.addr;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         status_r <= 1'b0;
         status_addr_r <= 6'h00;
      end else begin
         status_r <= status_nxt;
         status_addr_r <= req.addr;
      end
   end

   // Payload follows every cycle; only meaningful beside its pulse
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         power_r <= 1'b0;
         power_write_r <= 1'b0;
         power_wdata_r <= 8'h00;
      end else begin
         power_r <= power_nxt;
         power_write_r <= power_write_nxt;
         power_wdata_r <= req.wdata;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rdata_r <= 8'h00;
      end else if (rdata_load) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign ACC_RDATA = rdata_r;
   assign STROBE_PULSE = strobe_r;
   assign STROBE_CODE = strobe_code_r;
   assign STATUS_READ = status_r;
   assign STATUS_ADDR = status_addr_r;
   assign POWER_ACCESS = power_r;
   assign POWER_WRITE = power_write_r;
   assign POWER_WDATA = power_wdata_r;
   assign OUT_PIN_TWO_SELECT = pin_two_r.select;
   assign OUT_PIN_TWO_POLARITY = pin_two_r.polarity;
   assign OUT_PIN_ONE_SELECT = pin_one_r.select;
   assign OUT_PIN_ONE_POLARITY = pin_one_r.polarity;
   assign OUT_PIN_DRIVE_STRENGTH = drive_r;
   // Polarity applied here so pad logic sees the final level
   assign PIN_TWO_LEVEL = PIN_TWO_SIGNAL ^ pin_two_r.polarity;
   assign PIN_ONE_LEVEL = PIN_ONE_SIGNAL ^ pin_one_r.polarity;
endmodule // opc_regmap
`default_nettype wire

// ===== test/opc_host.sv
// Host model that issues header and data bytes
`default_nettype none
module opc_host (
   // Access lines toward the device
   input wire logic clk,
   output logic vld,
   output logic [7:0] hdr,
   output logic [7:0] wd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      vld = 1'b0;
      hdr = 8'h00;
      wd = 8'h00;
   end
   task automatic xfer(input logic [7:0] acc, input logic [5:0] adr, input logic [7:0] d);
      @(posedge clk);
      vld <= 1'b1;
      hdr <= acc + {2'b00, adr};
      wd <= d;
      @(posedge clk);
      vld <= 1'b0;
      // Released lines show no stale value
      hdr <= ~hdr;
      wd <= ~d;
   endtask
endmodule // opc_host
`default_nettype wire

// ===== test/opc_regmap_props.sv
// Port assertions for the register map
`default_nettype none
module opc_regmap_props (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Access from the serial interface
   input wire logic ACC_VALID,
   input wire logic [7:0] ACC_HEADER,
   input wire logic [7:0] ACC_WDATA,
   input wire logic [7:0] ACC_RDATA,
   // Region hits
   input wire logic STROBE_PULSE,
   input wire logic [5:0] STROBE_CODE,
   input wire logic STATUS_READ,
   input wire logic [5:0] STATUS_ADDR,
   input wire logic [7:0] STATUS_DATA,
   input wire logic POWER_ACCESS,
   input wire logic POWER_WRITE,
   input wire logic [7:0] POWER_WDATA,
   input wire logic [7:0] POWER_RDATA,
   // Pin configuration and levels
   input wire logic [5:0] OUT_PIN_TWO_SELECT,
   input wire logic OUT_PIN_TWO_POLARITY,
   input wire logic [5:0] OUT_PIN_ONE_SELECT,
   input wire logic OUT_PIN_ONE_POLARITY,
   input wire logic OUT_PIN_DRIVE_STRENGTH,
   input wire logic PIN_TWO_SIGNAL,
   input wire logic PIN_ONE_SIGNAL,
   input wire logic PIN_TWO_LEVEL,
   input wire logic PIN_ONE_LEVEL
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   wire rd = ACC_HEADER[7];
   wire brd = rd && ACC_HEADER[6];
   wire hit = ACC_VALID && ACC_HEADER[5:0] inside {[6'h30:6'h3d]};
   wire pwh = ACC_VALID && ACC_HEADER[5:0] == 6'h3e;
   property p_lvl; PIN_TWO_LEVEL == (PIN_TWO_SIGNAL ^ OUT_PIN_TWO_POLARITY); endproperty
   a_lvl: assert property (p_lvl) else $error("pin level");
   property p_lvl_one; PIN_ONE_LEVEL == (PIN_ONE_SIGNAL ^ OUT_PIN_ONE_POLARITY); endproperty
   a_lvl_one: assert property (p_lvl_one) else $error("pin one level");
   property p_two; ACC_VALID && !rd && ACC_HEADER[5:0] == 6'h00 |=>
      {OUT_PIN_TWO_POLARITY, OUT_PIN_TWO_SELECT} == $past(ACC_WDATA[6:0]); endproperty
   a_two: assert property (p_two) else $error("pin two select");
   property p_one; ACC_VALID && !rd && ACC_HEADER[5:0] == 6'h01 |=>
      {OUT_PIN_DRIVE_STRENGTH, OUT_PIN_ONE_POLARITY, OUT_PIN_ONE_SELECT} == $past(ACC_WDATA); endproperty
   a_one: assert property (p_one) else $error("pin one config");
   property p_stb; hit && !brd |=> STROBE_PULSE && {2'b00, STROBE_CODE} == ($past(ACC_HEADER) & 8'h3f); endproperty
   a_stb: assert property (p_stb) else $error("strobe");
   property p_sts; hit && brd |=> STATUS_READ && !STROBE_PULSE && ACC_RDATA == $past(STATUS_DATA)
      && STATUS_ADDR == $past(ACC_HEADER[5:0]); endproperty
   a_sts: assert property (p_sts) else $error("status read");
   property p_pwr; pwh |=> POWER_ACCESS && POWER_WRITE == !$past(rd)
      && (!POWER_WRITE || POWER_WDATA == $past(ACC_WDATA)); endproperty
   a_pwr: assert property (p_pwr) else $error("power access");
   property p_prd; pwh && rd |=> ACC_RDATA == $past(POWER_RDATA); endproperty
   a_prd: assert property (p_prd) else $error("power read");
   property p_rsv; ACC_VALID && rd && ACC_HEADER[5:0] == 6'h00 |=> !ACC_RDATA[7]; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit");
   property p_idle; !ACC_VALID |=> !(STROBE_PULSE || STATUS_READ || POWER_ACCESS); endproperty
   a_idle: assert property (p_idle) else $error("stray pulse");
endmodule // opc_regmap_props
bind opc_regmap opc_regmap_props i_props (.REF_CLK, .RST, .ACC_VALID, .STROBE_PULSE, .STATUS_READ,
   .POWER_ACCESS, .POWER_WRITE, .OUT_PIN_ONE_POLARITY, .OUT_PIN_DRIVE_STRENGTH, .OUT_PIN_TWO_POLARITY,
   .PIN_TWO_SIGNAL, .PIN_TWO_LEVEL, .ACC_HEADER, .ACC_WDATA, .ACC_RDATA, .STATUS_DATA, .POWER_RDATA,
   .STROBE_CODE, .OUT_PIN_TWO_SELECT, .OUT_PIN_ONE_SELECT, .STATUS_ADDR, .POWER_WDATA,
   .PIN_ONE_SIGNAL, .PIN_ONE_LEVEL);
`default_nettype wire

// ===== test/output_pin_config_and_strobe_map_bench.sv
// Self-checking bench for the register map
`default_nettype none
module output_pin_config_and_strobe_map_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] acc, adr, wd, exp;} opc_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic vld, stb, sts, pwr, pwr_w, drv, lv1, lv2;
   logic sig = 1'b1;
   logic [7:0] hdr, wd, rd, pwd;
   logic [5:0] code, sad;
   int miscompares = 0;
   int checks = 0;
   opc_row_t rows [9] = '{'{8'h80, 8'h00, 8'h00, 8'h29}, '{8'h80, 8'h01, 8'h00, 8'h2e},
      '{8'h00, 8'h00, 8'hff, 8'h00}, '{8'hc0, 8'h00, 8'h00, 8'h7f}, '{8'h40, 8'h01, 8'hc5, 8'h00},
      '{8'h80, 8'h01, 8'h00, 8'hc5}, '{8'h00, 8'h05, 8'h77, 8'h00}, '{8'h80, 8'h05, 8'h00, 8'h00},
      '{8'hc0, 8'h3e, 8'h00, 8'hc3}};
   opc_host i_host (.clk(clk), .vld(vld), .hdr(hdr), .wd(wd));
   opc_regmap i_dut (.REF_CLK(clk), .RST(rst), .ACC_VALID(vld), .ACC_HEADER(hdr), .ACC_WDATA(wd),
      .ACC_RDATA(rd), .STROBE_PULSE(stb), .STROBE_CODE(code), .STATUS_READ(sts), .STATUS_ADDR(sad),
      .STATUS_DATA(8'h5a), .POWER_ACCESS(pwr), .POWER_WRITE(pwr_w), .POWER_WDATA(pwd), .POWER_RDATA(8'hc3),
      .OUT_PIN_TWO_SELECT(), .OUT_PIN_TWO_POLARITY(), .OUT_PIN_ONE_SELECT(), .OUT_PIN_ONE_POLARITY(),
      .OUT_PIN_DRIVE_STRENGTH(drv), .PIN_TWO_SIGNAL(sig), .PIN_ONE_SIGNAL(sig), .PIN_TWO_LEVEL(lv2),
      .PIN_ONE_LEVEL(lv1));
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial forever #10 clk = ~clk;
   initial begin
      #20000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         i_host.xfer(rows[i].acc, rows[i].adr[5:0], rows[i].wd);
         #1 if (rows[i].acc[7]) chk("row read", rd, rows[i].exp);
      end
      chk("drive and level", {5'h00, drv, lv2, lv1}, 8'h04);
      @(posedge clk) sig <= 1'b0;
      #1 chk("inverted level", {6'h00, lv2, lv1}, 8'h03);
      for (int a = 8'h30; a <= 8'h3d; a++) begin
         i_host.xfer(a[0] ? 8'h80 : 8'h00, a[5:0], 8'h00);
         #1 chk("strobe", {stb, 1'b0, code}, {2'b10, a[5:0]});
      end
      i_host.xfer(8'hc0, 6'h34, 8'h00);
      #1 chk("status", rd, 8'h5a);
      chk("status pulse", {sts, stb, sad}, {2'b10, 6'h34});
      i_host.xfer(8'h40, 6'h3e, 8'h96);
      #1 chk("power write", pwd ^ {pwr, pwr_w, 6'h00}, 8'h56);
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk("reset levels", {5'h00, drv, lv2, lv1}, 8'h00);
      i_host.xfer(8'h80, 6'h01, 8'h00);
      #1 chk("second reset", rd, 8'h2e);
      i_host.xfer(8'h80, 6'h00, 8'h00);
      #1 chk("second reset pin two", rd, 8'h29);
      end_of_test();
   end
endmodule // output_pin_config_and_strobe_map_bench
`default_nettype wire
